// >>> design/tape_data_path.sv
/*
  Seven-track tape data path: packs and unpacks 12-bit words as two
  6-bit tape bytes, adds and checks parity, generates write strobes,
  longitudinal-check clear, file mark write and detection, and stop timing.
  Assumes tape-side and control-board inputs are asynchronous pins and
  are synchronised here, except data_in_pulse; registers reached over AHB-Lite.
*/
//
// Summary of operation
// - word goes out as two parity bytes
// - holding register loaded by cpu strobe
// - tape run clears scalers and selector
// - prescaler divides data clock by sixteen
// - first strobe sends upper byte
// - write strobe clears timeout scaler
// - selector toggles after each strobe except a mark strobe
// - second strobe pulses word request
// - check stage pulses write amp clear
// - final stage raises stop request
// - gap or mark disables drivers
// - long gap blocks strobes, scalers run
// - odd parity, even for gap or mark
// - read bytes parity checked
// - mark write drives code fifteen
// - mark strobe then latch blocks strobes
// - read strobe clears both scalers
// - read strobes fill upper then lower
// - second read strobe requests word
// - no read strobes leads to stop
// - double mark code raises mark flag
// - later read strobe withdraws mark flag
`timescale 1ns/1ps
module tape_data_path #(
  parameter int prescale_div = tape_data_pkg::prescale_div,
  parameter int pulse_cycles = tape_data_pkg::pulse_cycles
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        clk_en,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // control board pins
  input  wire logic        tape_run,
  input  wire logic        data_clock,
  input  wire logic        write_data,
  input  wire logic        gap_or_mark_write,
  input  wire logic        mark_write,
  input  wire logic        read_strobe,
  input  wire logic        data_in_pulse,
  output logic             word_request_pulse,
  output logic             stop_request,
  output logic             parity_error,
  output logic             mark_flag,
  // tape transport pins
  input  wire logic [5:0]  read_byte,
  input  wire logic        read_parity,
  output logic      [5:0]  write_byte,
  output logic             write_parity,
  output logic             write_strobe,
  output logic             drivers_enable,
  output logic             write_amp_clear,
  // cpu data out
  output logic      [11:0] cpu_word,
  output logic             cpu_word_valid
);

  ////////////////////////////////////////////////////////////////////////
  // input synchronisers
  localparam int n_sync = 13;
  logic [n_sync-1:0] sync1_q;
  logic [n_sync-1:0] sync2_q;
  logic [n_sync-1:0] raw_in;
  assign raw_in = {read_parity, read_byte, tape_run, data_clock, write_data,
                   gap_or_mark_write, mark_write, read_strobe};
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
    end
    else if (clk_en)
    begin
      sync1_q <= raw_in;
      sync2_q <= sync1_q;
    end
  end
  logic       run_s;
  logic       dclk_s;
  logic       wdata_s;
  logic       gap_s;
  logic       mark_s;
  logic       rstb_s;
  logic [5:0] rbyte_s;
  logic       rpar_s;
  assign rpar_s  = sync2_q[12];
  assign rbyte_s = sync2_q[11:6];
  assign run_s   = sync2_q[5];
  assign dclk_s  = sync2_q[4];
  assign wdata_s = sync2_q[3];
  assign gap_s   = sync2_q[2];
  assign mark_s  = sync2_q[1];
  assign rstb_s  = sync2_q[0];
  logic dclk_prev_q;
  logic rstb_prev_q;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dclk_prev_q <= 1'b0;
      rstb_prev_q <= 1'b0;
    end
    else if (clk_en)
    begin
      dclk_prev_q <= dclk_s;
      rstb_prev_q <= rstb_s;
    end
  end
  logic dclk_rise;
  logic rstb_rise;
  assign dclk_rise = dclk_s & ~dclk_prev_q;
  assign rstb_rise = rstb_s & ~rstb_prev_q;

  ////////////////////////////////////////////////////////////////////////
  // ahb-lite slave
  logic        ph_wr_q;
  logic        ph_rd_q;
  logic [7:0]  ph_addr_q;
  logic [31:0] ctrl_q;
  logic        cpu_load;
  logic        addr_take;
  assign addr_take = hsel & hready & htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ph_wr_q   <= 1'b0;
      ph_rd_q   <= 1'b0;
      ph_addr_q <= 8'h00;
    end
    else if (clk_en)
    begin
      ph_wr_q   <= addr_take & hwrite;
      ph_rd_q   <= addr_take & ~hwrite;
      ph_addr_q <= haddr[7:0];
    end
  end
  logic write_sel;
  assign write_sel = ctrl_q[tape_data_pkg::ctrl_write_sel_bit];
  assign cpu_load  = ph_wr_q & (ph_addr_q == tape_data_pkg::wdata_off);
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ctrl_q <= tape_data_pkg::ctrl_reset;
    else if (clk_en && ph_wr_q && ph_addr_q == tape_data_pkg::ctrl_off)
      ctrl_q <= {30'h0, hwdata[1:0]};
  end

  ////////////////////////////////////////////////////////////////////////
  // scalers and strobe pulse
  logic [3:0]  pre_q;
  logic        tick;
  logic [tape_data_pkg::timeout_width-1:0] tmo_q;
  logic [15:0] pulse_q;
  logic        pulse_on;
  logic        mark_latch_q;
  logic        sel_q;
  logic        strobe_ok;
  logic        strobe_fire;
  assign tick = run_s & dclk_rise & (pre_q == 4'(prescale_div - 1));
  assign pulse_on = (pulse_q != 16'h0000);
  // strobes need select, data, no gap; mark alone until latched
  assign strobe_ok = write_sel & ~mark_latch_q
                   & ((wdata_s & ~gap_s) | mark_s);
  assign strobe_fire = tick & strobe_ok;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      pre_q <= 4'h0;
    else if (clk_en)
    begin
      if (!run_s || rstb_rise)
        pre_q <= 4'h0;
      else if (dclk_rise)
        pre_q <= (pre_q == 4'(prescale_div - 1)) ? 4'h0 : pre_q + 4'h1;
    end
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      tmo_q <= '0;
    else if (clk_en)
    begin
      if (!run_s || rstb_rise || strobe_fire)
        tmo_q <= '0;
      else if (tick && !tmo_q[tape_data_pkg::final_stage])
        tmo_q <= tmo_q + 1'b1;
    end
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      pulse_q <= 16'h0000;
    else if (clk_en)
    begin
      if (strobe_fire)
        pulse_q <= 16'(pulse_cycles);
      else if (pulse_on)
        pulse_q <= pulse_q - 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // stop and write amplifier clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      write_amp_clear <= 1'b0;
      stop_request    <= 1'b0;
    end
    else if (clk_en)
    begin
      write_amp_clear <= write_sel & tick
                       & tmo_q[tape_data_pkg::check_stage]
                       & ~tmo_q[tape_data_pkg::final_stage];
      stop_request <= run_s & tmo_q[tape_data_pkg::final_stage];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // holding register, selector, write outputs
  logic [11:0] hold_q;
  logic        rd_lower;
  logic [5:0]  out_byte;
  assign rd_lower = rstb_rise & sel_q & ~write_sel;
  assign out_byte = mark_s ? tape_data_pkg::mark_code
                  : (sel_q ? hold_q[5:0] : hold_q[11:6]);
  function automatic logic parity_of(input logic [5:0] b, input logic even);
    parity_of = ^b ^ ~even;
  endfunction
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hold_q <= 12'h000;
    else if (clk_en)
    begin
      if (cpu_load && write_sel)
        hold_q <= hwdata[11:0];
      else if (rstb_rise && !write_sel && !sel_q)
        hold_q[11:6] <= rbyte_s;
      else if (rd_lower)
        hold_q[5:0] <= rbyte_s;
    end
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      sel_q <= 1'b0;
    else if (clk_en)
    begin
      if (!run_s)
        sel_q <= 1'b0;
      else if ((strobe_fire && !mark_s) || (rstb_rise && !write_sel))
        sel_q <= ~sel_q;
    end
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      write_byte     <= 6'h00;
      write_parity   <= 1'b0;
      write_strobe   <= 1'b0;
      drivers_enable <= 1'b0;
    end
    else if (clk_en)
    begin
      write_strobe <= pulse_on;
      drivers_enable <= write_sel & ~gap_s;
      if (strobe_fire)
      begin
        write_byte   <= out_byte;
        write_parity <= parity_of(out_byte, gap_s);
      end
    end
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      mark_latch_q <= 1'b0;
    else if (clk_en)
    begin
      if (!mark_s)
        mark_latch_q <= 1'b0;
      else if (write_strobe && !pulse_on)
        mark_latch_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // word request, parity check, mark detect, cpu data
  logic word_ready_q;
  logic mark_armed_q;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      word_request_pulse <= 1'b0;
      parity_error       <= 1'b0;
    end
    else if (clk_en)
    begin
      word_request_pulse <= (strobe_fire & sel_q & ~mark_s) | rd_lower;
      if (rstb_rise)
        parity_error <= parity_of(rbyte_s, gap_s) != rpar_s;
    end
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mark_flag    <= 1'b0;
      mark_armed_q <= 1'b0;
    end
    else if (clk_en)
    begin
      if (!run_s || gap_s)
      begin
        mark_flag    <= 1'b0;
        mark_armed_q <= 1'b0;
      end
      else if (rd_lower)
      begin
        mark_flag <= (hold_q[11:6] == tape_data_pkg::mark_code)
                   & (rbyte_s == tape_data_pkg::mark_code);
        mark_armed_q <= 1'b1;
      end
      else if (rstb_rise && mark_armed_q)
        mark_flag <= 1'b0;
    end
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cpu_word       <= 12'h000;
      cpu_word_valid <= 1'b0;
      word_ready_q   <= 1'b0;
    end
    else if (clk_en)
    begin
      cpu_word_valid <= data_in_pulse & word_ready_q;
      if (data_in_pulse && word_ready_q)
        cpu_word <= hold_q;
      if (rd_lower)
        word_ready_q <= 1'b1;
      else if (data_in_pulse)
        word_ready_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register read data
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (clk_en)
    begin
      hrdata <= 32'h0000_0000;
      if (addr_take && !hwrite)
        case (haddr[7:0])
          tape_data_pkg::ctrl_off:   hrdata <= ctrl_q;
          tape_data_pkg::status_off: hrdata <= {27'h0, word_ready_q, sel_q,
                                                parity_error, mark_latch_q, mark_flag};
          tape_data_pkg::wdata_off:  hrdata <= {20'h0_0000, hold_q};
          tape_data_pkg::rdata_off:  hrdata <= {20'h0_0000, cpu_word};
          default:                   hrdata <= 32'h0000_0000;
        endcase
    end
  end
endmodule

// >>> design/tape_data_pkg.sv
/*
  Shared constants for the 7-track tape data path: register map, field
  layouts, reset values and timing counts.
  Assumes a 32-bit AHB-Lite register bus; no other surroundings.
*/
package tape_data_pkg;

  // register byte offsets
  localparam logic [7:0] ctrl_off   = 8'h00;
  localparam logic [7:0] status_off = 8'h04;
  localparam logic [7:0] wdata_off  = 8'h08;
  localparam logic [7:0] rdata_off  = 8'h0C;

  // control register fields
  localparam int ctrl_write_sel_bit = 0;
  localparam int ctrl_write_en_bit  = 1;

  // status register fields
  localparam int st_mark_flag_bit = 0;
  localparam int st_mark_latch_bit = 1;
  localparam int st_parity_err_bit = 2;
  localparam int st_selector_bit  = 3;
  localparam int st_word_ready_bit = 4;

  // field widths and codes
  localparam int word_width = 12;
  localparam int byte_width = 6;
  localparam logic [5:0] mark_code = 6'h0F;

  // reset values
  localparam logic [31:0] ctrl_reset = 32'h0000_0000;

  // timing: prescaler divide, strobe pulse length
  localparam int prescale_div = 16;
  localparam int pulse_ns = 3000;
  localparam int clk_ns = 4;
  localparam int pulse_cycles = (pulse_ns + clk_ns - 1) / clk_ns;

  // timeout scaler width and stage bit indices; the scaler counts prescaler ticks
  localparam int timeout_width = 4;
  localparam int check_stage = 2;
  localparam int final_stage = 3;

endpackage

// >>> verif/tape_data_checker.sv
/*
  checker: port-level properties of the tape data path.
  bound to tape_data_path; needs only its ports.
*/
`timescale 1ns/1ps
module tape_data_checker #(
  parameter int prescale_div = 16,
  parameter int pulse_cycles = 750
) (
  // clock and reset
  input wire logic       hclk,
  input wire logic       hresetn,
  // observed pins
  input wire logic       clk_en,
  input wire logic       tape_run,
  input wire logic       gap_or_mark_write,
  input wire logic       mark_write,
  input wire logic       data_in_pulse,
  input wire logic       word_request_pulse,
  input wire logic       stop_request,
  input wire logic [5:0] write_byte,
  input wire logic       write_parity,
  input wire logic       write_strobe,
  input wire logic       drivers_enable,
  input wire logic       write_amp_clear,
  input wire logic       cpu_word_valid
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ////////////////////////////////////////
  chk_wreq_pulse:
    assert property (word_request_pulse |=> !word_request_pulse) else $error("long word request");
  chk_amp_pulse:
    assert property (write_amp_clear |=> !write_amp_clear) else $error("long amp clear");
  chk_word_out:
    assert property (clk_en && data_in_pulse |=> cpu_word_valid) else $error("no word out");
  chk_run_idle:
    assert property (!tape_run [*6] |-> !stop_request) else $error("stop while not running");
  chk_gap_drivers:
    assert property (gap_or_mark_write [*5] |-> !drivers_enable) else $error("drivers on in gap");
  chk_parity_gen:
    assert property ($rose(write_strobe) |-> write_parity == (^write_byte ^ !gap_or_mark_write))
      else $error("bad write parity");
  chk_mark_code:
    assert property ($rose(write_strobe) && mark_write |-> write_byte == tape_data_pkg::mark_code)
      else $error("bad mark code");
  chk_strobe_width:
    assert property ($rose(write_strobe) |-> write_strobe [*8]) else $error("short strobe");
  chk_byte_hold:
    assert property (write_strobe && $past(write_strobe) |-> $stable({write_byte, write_parity}))
      else $error("byte moved in strobe");
  cover property (word_request_pulse);
  cover property (write_amp_clear);
  cover property (cpu_word_valid);
endmodule

bind tape_data_path tape_data_checker #(.prescale_div(prescale_div), .pulse_cycles(pulse_cycles))
  chk (.hclk, .hresetn, .clk_en, .tape_run, .gap_or_mark_write, .mark_write, .data_in_pulse,
  .word_request_pulse, .stop_request, .write_byte, .write_parity, .write_strobe,
  .drivers_enable, .write_amp_clear, .cpu_word_valid);

// >>> verif/tape_partner.sv
/*
  partner: control board and tape transport facing the data path.
  mode inputs come from the testbench; all on hclk.
*/
`timescale 1ns/1ps
module tape_partner (
  // clock, modes and word request
  input wire logic  hclk,
  input wire logic  run,
  input wire logic  clk_on,
  input wire logic  wr_mode,
  input wire logic  rd_mode,
  input wire logic  word_request_pulse,
  // pins to the data path
  output logic       tape_run,
  output logic       data_clock,
  output logic       write_data,
  output logic       data_in_pulse,
  output logic       read_strobe,
  output logic [5:0] read_byte,
  output logic       read_parity
);
  logic [1:0] div_q;
  logic       sent_q;
  initial
  begin
    {tape_run, data_clock, write_data, data_in_pulse, read_strobe, read_parity} = 6'h00;
    read_byte = 6'h00;
    div_q = 2'h0;
    sent_q = 1'b0;
  end
  always @(posedge hclk)
  begin
    div_q <= div_q + 2'h1;
    tape_run <= run;
    data_clock <= run && clk_on && div_q[1];
    sent_q <= wr_mode && (sent_q || word_request_pulse);
    write_data <= wr_mode && !sent_q && !word_request_pulse;
    data_in_pulse <= rd_mode && word_request_pulse;
  end
  // one tape byte; lines flip four cycles after the strobe drops
  task send(input logic [5:0] b, input logic p);
    @(posedge hclk);
    read_byte <= b;
    read_parity <= p;
    repeat (4) @(posedge hclk);
    read_strobe <= 1'b1;
    repeat (4) @(posedge hclk);
    read_strobe <= 1'b0;
    repeat (4) @(posedge hclk);
    read_byte <= ~b;
    read_parity <= ~p;
    repeat (8) @(posedge hclk);
  endtask
endmodule

// >>> verif/testbench.sv
/*
  testbench: bus, write, gap, mark and read scenarios for the tape data path.
  tape_partner stands for the control board and transport.
*/
`timescale 1ns/1ps
module testbench;
  logic        hclk, hresetn, clk_en, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        tape_run, data_clock, write_data, gap_or_mark_write, mark_write, read_strobe;
  logic        data_in_pulse, read_parity, word_request_pulse, stop_request, parity_error;
  logic        mark_flag, write_parity, write_strobe, drivers_enable, write_amp_clear;
  logic        cpu_word_valid, run, clk_on, wr_mode, rd_mode, prev;
  logic [5:0]  read_byte, write_byte;
  logic [11:0] cpu_word;
  int          fail_count, n_compared, rises, wreqs;

  tape_data_path #(.pulse_cycles(10)) dut (.hclk, .hresetn, .clk_en, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .tape_run,
    .data_clock, .write_data, .gap_or_mark_write, .mark_write, .read_strobe, .data_in_pulse,
    .word_request_pulse, .stop_request, .parity_error, .mark_flag, .read_byte, .read_parity,
    .write_byte, .write_parity, .write_strobe, .drivers_enable, .write_amp_clear, .cpu_word,
    .cpu_word_valid);
  tape_partner p (.hclk, .run, .clk_on, .wr_mode, .rd_mode, .word_request_pulse, .tape_run,
    .data_clock, .write_data, .data_in_pulse, .read_strobe, .read_byte, .read_parity);

  initial
  begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  ////////////////////////////////////////
  task end_sim;
    $display("compared %0d, wrong %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  function logic sig(input int k);
    case (k)
      0: sig = hreadyout;
      1: sig = write_strobe;
      3: sig = write_amp_clear;
      default: sig = stop_request;
    endcase
  endfunction
  // waits until a signal reaches a value; tallies strobe rises and word requests
  task wait_for(input int k, input logic v, input int lim);
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      if (write_strobe === 1'b1 && prev !== 1'b1) rises++;
      if (word_request_pulse === 1'b1) wreqs++;
      prev = write_strobe;
      n++;
    end
    while (sig(k) !== v && n < lim);
    if (sig(k) !== v)
    begin
      fail_count++;
      $display("wrong value at %0t: wait %0d timed out", $time, k);
      end_sim();
    end
  endtask
  task bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    wait_for(0, 1'b1, 20);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_for(0, 1'b1, 20);
    d = hrdata;
  endtask
  task idle;
    {run, clk_on, wr_mode, rd_mode, gap_or_mark_write, mark_write} <= 6'h00;
    repeat (10) @(posedge hclk);
    check(stop_request, 1'b0, "stop after run drop");
  endtask
  ////////////////////////////////////////
  task t_regs;
    bus(1'b0, 32'h0000_0000, 32'h0);
    check(d, 32'h0000_0000, "ctrl reset");
    check(hresp, 1'b0, "okay response");
    bus(1'b1, 32'h0000_0000, 32'h0000_0001);
    bus(1'b0, 32'h0000_0020, 32'h0);
    check(d, 32'h0000_0000, "unmapped");
    bus(1'b0, 32'h0000_0000, 32'h0);
    check(d, 32'h0000_0001, "ctrl");
  endtask
  task t_write;
    bus(1'b1, 32'h0000_0008, 32'h0000_0B5A);
    bus(1'b0, 32'h0000_0008, 32'h0);
    check(d[11:0], 12'hB5A, "hold");
    {wr_mode, run, clk_on} <= 3'h7;
    rises = 0;
    wreqs = 0;
    wait_for(1, 1'b1, 1000);
    check(write_byte, 6'h2D, "upper");
    check(write_parity, 1'b1, "upper par");
    check(drivers_enable, 1'b1, "drivers");
    wait_for(1, 1'b0, 100);
    wait_for(1, 1'b1, 1000);
    check(write_byte, 6'h1A, "lower");
    check(write_parity, 1'b0, "lower par");
    wait_for(3, 1'b1, 3000);
    wait_for(4, 1'b1, 3000);
    check(wreqs, 1, "word requests");
    check(rises, 2, "strobes");
    idle();
  endtask
  task t_gap;
    {gap_or_mark_write, run} <= 2'h3;
    repeat (600) @(posedge hclk);
    check(stop_request, 1'b0, "stop without clocks");
    check(drivers_enable, 1'b0, "gap drivers");
    rises = 0;
    clk_on <= 1'b1;
    wait_for(4, 1'b1, 3000);
    check(rises, 0, "gap strobes");
    idle();
  endtask
  task t_mark_write;
    {gap_or_mark_write, mark_write, run, clk_on} <= 4'hF;
    rises = 0;
    wait_for(1, 1'b1, 1000);
    check(write_byte, 6'h0F, "mark byte");
    check(write_parity, 1'b0, "mark par");
    check(drivers_enable, 1'b0, "mark drivers");
    wait_for(4, 1'b1, 3000);
    check(rises, 1, "mark strobes");
    idle();
  endtask
  task t_read;
    bus(1'b1, 32'h0000_0000, 32'h0);
    {rd_mode, run, clk_on} <= 3'h7;
    p.send(6'h2D, 1'b1);
    p.send(6'h1A, 1'b0);
    check(cpu_word, 12'hB5A, "cpu word");
    check(parity_error, 1'b0, "good parity");
    bus(1'b0, 32'h0000_000C, 32'h0);
    check(d[11:0], 12'hB5A, "last word");
    p.send(6'h01, 1'b1);
    check(parity_error, 1'b1, "bad parity");
    wait_for(4, 1'b1, 3000);
    check(stop_request, 1'b1, "read stop");
    idle();
  endtask
  task t_mark_read;
    {rd_mode, run, clk_on} <= 3'h7;
    p.send(6'h0F, 1'b0);
    p.send(6'h0F, 1'b0);
    check(mark_flag, 1'b1, "mark seen");
    check(parity_error, 1'b1, "mark in odd");
    bus(1'b0, 32'h0000_0004, 32'h0);
    check(d, 32'h0000_0005, "status");
    p.send(6'h2D, 1'b1);
    check(mark_flag, 1'b0, "mark withdrawn");
    idle();
  endtask
  ////////////////////////////////////////
  initial
  begin
    {hresetn, hsel, hwrite, gap_or_mark_write, mark_write, run, clk_on, wr_mode} = 8'h00;
    {clk_en, rd_mode, prev} = 3'h4;
    {haddr, hwdata} = 64'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    {fail_count, n_compared, rises, wreqs} = 128'h0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs();
    t_write();
    t_gap();
    t_mark_write();
    t_read();
    t_mark_read();
    end_sim();
  end
endmodule
